/* File: include/mbrag_consts.svh */
// Constants of the mode based register access guard.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MBRAG_CONSTS_SVH
`define MBRAG_CONSTS_SVH

`define MBRAG_ADDR_W        16
`define MBRAG_DATA_W        8
`define MBRAG_SFR_BASE      16'hff00
`define MBRAG_SFR_LAST      16'hffff
`define MBRAG_CPU_SFR_FIRST 8'h00
`define MBRAG_CPU_SFR_LAST  8'h1f
`define MBRAG_MMU_SFR_FIRST 8'h20
`define MBRAG_MMU_SFR_LAST  8'h2f
`define MBRAG_STP_SFR_FIRST 8'h28
`define MBRAG_STP_SFR_LAST  8'h2b
`define MBRAG_GRANT_SFR     8'h2c
`define MBRAG_HW_SFR_FIRST  8'h40
`define MBRAG_HW_SFR_LAST   8'h7f
`define MBRAG_HW_GROUP_W    3
`define MBRAG_GRANT_RESET   8'h00
`define MBRAG_SEG_COUNT     4
`define MBRAG_SEG_EN_RESET  4'h0
`define MBRAG_SEG_SFR_FIRST 8'h20
`define MBRAG_SEG_SHIFT     14
`define MBRAG_FW_BASE       16'he000
`define MBRAG_FW_LAST       16'hefff
`define MBRAG_BOOT_CYCLES   4'h8

`endif

/* File: include/mbrag_pkg.sv */
// Types shared by the access guard and its mode checker.
// Assumes mbrag_consts.svh sits on the include path.
`include "mbrag_consts.svh"

package mbrag_pkg;

    typedef enum logic [2:0] {
        MODE_SYSTEM   = 3'b001,
        MODE_USER     = 3'b010,
        MODE_FIRMWARE = 3'b100
    } mbrag_mode_e;

    typedef enum logic [2:0] {
        ST_BOOT  = 3'b001,
        ST_RUN   = 3'b010,
        ST_FAULT = 3'b100
    } mbrag_state_e;

    typedef struct packed {
        logic                       valid;
        logic                       write;
        logic [`MBRAG_ADDR_W-1:0]   addr;
        logic [`MBRAG_DATA_W-1:0]   wdata;
        mbrag_mode_e                mode;
    } mbrag_req_s;

    typedef struct packed {
        logic sfr_ok;
        logic mem_ok;
        logic is_sfr;
        logic is_grant;
        logic is_seg;
    } mbrag_perm_s;

endpackage : mbrag_pkg

/* File: logic/mbrag_perm_check.sv */
// Combinational permission check of one access against mode and settings.
// Assumes settings come from registers in the guard on the same clock.
`include "mbrag_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mbrag_perm_check (
    input  wire mbrag_pkg::mbrag_req_s            req_in,
    input  wire logic [`MBRAG_DATA_W-1:0]          user_grant_in,
    input  wire logic [`MBRAG_DATA_W-1:0]          fw_grant_in,
    input  wire logic [`MBRAG_SEG_COUNT-1:0]       seg_en_in,
    output var  mbrag_pkg::mbrag_perm_s            perm_out
);

    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    logic [7:0]                    off;
    logic                          is_sfr;
    logic [`MBRAG_HW_GROUP_W-1:0]  grp;

    always_comb
    begin
        is_sfr = (req_in.addr >= `MBRAG_SFR_BASE);
        off    = req_in.addr[7:0];
        grp    = off[5:3];
        perm_out.is_sfr   = is_sfr;
        perm_out.is_grant = is_sfr && (off == `MBRAG_GRANT_SFR);
        perm_out.is_seg   = is_sfr && in_range(off, `MBRAG_SEG_SFR_FIRST,
                                               8'(`MBRAG_SEG_SFR_FIRST + `MBRAG_SEG_COUNT - 1));
        perm_out.sfr_ok   = 1'b0;
        perm_out.mem_ok   = 1'b0;
        if (is_sfr)
        begin
            if (in_range(off, `MBRAG_CPU_SFR_FIRST, `MBRAG_CPU_SFR_LAST))
                perm_out.sfr_ok = 1'b1;
            else if (in_range(off, `MBRAG_MMU_SFR_FIRST, `MBRAG_MMU_SFR_LAST))
                perm_out.sfr_ok = (req_in.mode == mbrag_pkg::MODE_SYSTEM);
            else if (in_range(off, `MBRAG_HW_SFR_FIRST, `MBRAG_HW_SFR_LAST))
            begin
                unique case (req_in.mode)
                    mbrag_pkg::MODE_SYSTEM:   perm_out.sfr_ok = 1'b1;
                    mbrag_pkg::MODE_USER:     perm_out.sfr_ok = user_grant_in[grp];
                    mbrag_pkg::MODE_FIRMWARE: perm_out.sfr_ok = fw_grant_in[grp];
                    default:                  perm_out.sfr_ok = 1'b0;
                endcase
            end
        end
        else if ((req_in.addr >= `MBRAG_FW_BASE) && (req_in.addr <= `MBRAG_FW_LAST))
            perm_out.mem_ok = (req_in.mode == mbrag_pkg::MODE_FIRMWARE);
        else
            perm_out.mem_ok = (req_in.mode == mbrag_pkg::MODE_FIRMWARE)
                || seg_en_in[req_in.addr[`MBRAG_ADDR_W-1:`MBRAG_SEG_SHIFT]];
    end

endmodule : mbrag_perm_check

`default_nettype wire

/* File: logic/mbrag_guard.sv */
// Access guard between the CPU core and memory plus special function registers.
// Assumes the core holds a request one cycle and reads the answer two cycles later, or the next cycle for a refused read.
`include "mbrag_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mbrag_guard (
    input  wire logic                          CLK_SYS_IN,
    input  wire logic                          RST_N_IN,
    input  wire logic                          REQ_VALID_IN,
    input  wire logic                          REQ_WRITE_IN,
    input  wire logic [`MBRAG_ADDR_W-1:0]      REQ_ADDR_IN,
    input  wire logic [`MBRAG_DATA_W-1:0]      REQ_WDATA_IN,
    input  wire logic [2:0]                    CPU_MODE_IN,
    input  wire logic [`MBRAG_DATA_W-1:0]      BUS_RDATA_IN,
    output logic                               READY_OUT,
    output logic                               BUS_VALID_OUT,
    output logic                               BUS_WRITE_OUT,
    output logic [`MBRAG_ADDR_W-1:0]           BUS_ADDR_OUT,
    output logic [`MBRAG_DATA_W-1:0]           BUS_WDATA_OUT,
    output logic                               RESP_VALID_OUT,
    output logic [`MBRAG_DATA_W-1:0]           RESP_RDATA_OUT,
    output logic                               VIOLATION_OUT,
    output logic [`MBRAG_SEG_COUNT-1:0]        SEG_EN_OUT
);

    mbrag_pkg::mbrag_state_e                state_reg,      state_next;
    logic [3:0]                             boot_cnt_reg,   boot_cnt_next;
    logic [`MBRAG_DATA_W-1:0]               ugrant_reg,     ugrant_next;
    logic [`MBRAG_DATA_W-1:0]               fgrant_reg,     fgrant_next;
    logic [`MBRAG_SEG_COUNT-1:0]            seg_en_reg,     seg_en_next;
    logic                                   ready_reg,      ready_next;
    logic                                   bvalid_reg,     bvalid_next;
    logic                                   bwrite_reg,     bwrite_next;
    logic [`MBRAG_ADDR_W-1:0]               baddr_reg,      baddr_next;
    logic [`MBRAG_DATA_W-1:0]               bwdata_reg,     bwdata_next;
    logic                                   rvalid_reg,     rvalid_next;
    logic [`MBRAG_DATA_W-1:0]               rdata_reg,      rdata_next;
    logic                                   viol_reg,       viol_next;
    logic                                   pend_rd_reg,    pend_rd_next;
    mbrag_pkg::mbrag_req_s                  req;
    mbrag_pkg::mbrag_perm_s                 perm;
    logic                                   allowed;

    always_comb
    begin
        req.valid = REQ_VALID_IN;
        req.write = REQ_WRITE_IN;
        req.addr  = REQ_ADDR_IN;
        req.wdata = REQ_WDATA_IN;
        unique case (CPU_MODE_IN)
            3'b001:  req.mode = mbrag_pkg::MODE_SYSTEM;
            3'b100:  req.mode = mbrag_pkg::MODE_FIRMWARE;
            default: req.mode = mbrag_pkg::MODE_USER;
        endcase
    end

    mbrag_perm_check u_check (
        .req_in        (req),
        .user_grant_in (ugrant_reg),
        .fw_grant_in   (fgrant_reg),
        .seg_en_in     (seg_en_reg),
        .perm_out      (perm)
    );

    assign allowed = perm.is_sfr ? perm.sfr_ok : perm.mem_ok;

    always_comb
    begin
        state_next    = state_reg;
        boot_cnt_next = boot_cnt_reg;
        ugrant_next   = ugrant_reg;
        fgrant_next   = fgrant_reg;
        seg_en_next   = seg_en_reg;
        ready_next    = 1'b0;
        bvalid_next   = 1'b0;
        bwrite_next   = 1'b0;
        baddr_next    = baddr_reg;
        bwdata_next   = bwdata_reg;
        rvalid_next   = 1'b0;
        rdata_next    = rdata_reg;
        viol_next     = 1'b0;
        pend_rd_next  = 1'b0;
        if (pend_rd_reg)
        begin
            rvalid_next = 1'b1;
            rdata_next  = BUS_RDATA_IN;
        end
        unique case (state_reg)
            mbrag_pkg::ST_BOOT:
            begin
                ugrant_next = `MBRAG_GRANT_RESET;
                fgrant_next = `MBRAG_GRANT_RESET;
                seg_en_next = `MBRAG_SEG_EN_RESET;
                if (boot_cnt_reg == `MBRAG_BOOT_CYCLES)
                begin
                    state_next = mbrag_pkg::ST_RUN;
                    ready_next = 1'b1;
                end
                else
                    boot_cnt_next = boot_cnt_reg + 4'h1;
            end
            mbrag_pkg::ST_RUN:
            begin
                ready_next = 1'b1;
                if (req.valid && !allowed)
                begin
                    viol_next   = 1'b1;
                    rvalid_next = !req.write;
                    rdata_next  = 8'h00;
                end
                else if (req.valid)
                begin
                    bvalid_next = 1'b1;
                    bwrite_next = req.write;
                    baddr_next  = req.addr;
                    bwdata_next = req.wdata;
                    pend_rd_next = !req.write;
                    if (req.write && perm.is_grant)
                    begin
                        ugrant_next = req.wdata;
                        fgrant_next = req.wdata;
                    end
                    if (req.write && perm.is_seg)
                        seg_en_next[req.addr[1:0]] = req.wdata[0];
                end
            end
            mbrag_pkg::ST_FAULT:
                state_next = mbrag_pkg::ST_BOOT;
            default:
                state_next = mbrag_pkg::ST_BOOT;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            state_reg    <= mbrag_pkg::ST_BOOT;
            boot_cnt_reg <= 4'h0;
            ugrant_reg   <= `MBRAG_GRANT_RESET;
            fgrant_reg   <= `MBRAG_GRANT_RESET;
            seg_en_reg   <= `MBRAG_SEG_EN_RESET;
            ready_reg    <= 1'b0;
            bvalid_reg   <= 1'b0;
            bwrite_reg   <= 1'b0;
            baddr_reg    <= 16'h0000;
            bwdata_reg   <= 8'h00;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 8'h00;
            viol_reg     <= 1'b0;
            pend_rd_reg  <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            boot_cnt_reg <= boot_cnt_next;
            ugrant_reg   <= ugrant_next;
            fgrant_reg   <= fgrant_next;
            seg_en_reg   <= seg_en_next;
            ready_reg    <= ready_next;
            bvalid_reg   <= bvalid_next;
            bwrite_reg   <= bwrite_next;
            baddr_reg    <= baddr_next;
            bwdata_reg   <= bwdata_next;
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            viol_reg     <= viol_next;
            pend_rd_reg  <= pend_rd_next;
        end
    end

    assign READY_OUT      = ready_reg;
    assign BUS_VALID_OUT  = bvalid_reg;
    assign BUS_WRITE_OUT  = bwrite_reg;
    assign BUS_ADDR_OUT   = baddr_reg;
    assign BUS_WDATA_OUT  = bwdata_reg;
    assign RESP_VALID_OUT = rvalid_reg;
    assign RESP_RDATA_OUT = rdata_reg;
    assign VIOLATION_OUT  = viol_reg;
    assign SEG_EN_OUT     = seg_en_reg;

endmodule : mbrag_guard

`default_nettype wire

/* File: tb/mbrag_guard_props.sv */
// Concurrent checks on the ports of the access guard.
// Assumes one clock and a synchronous active-low reset; bound to mbrag_guard.
`timescale 1ns/1ps
`default_nettype none
module mbrag_guard_props (
    input wire logic        CLK_SYS_IN,
    input wire logic        RST_N_IN,
    input wire logic        REQ_VALID_IN,
    input wire logic        REQ_WRITE_IN,
    input wire logic [15:0] REQ_ADDR_IN,
    input wire logic [2:0]  CPU_MODE_IN,
    input wire logic        READY_OUT,
    input wire logic        BUS_VALID_OUT,
    input wire logic [15:0] BUS_ADDR_OUT,
    input wire logic        RESP_VALID_OUT,
    input wire logic [7:0]  RESP_RDATA_OUT,
    input wire logic        VIOLATION_OUT,
    input wire logic [3:0]  SEG_EN_OUT
);
    wire logic       tk  = REQ_VALID_IN && READY_OUT;
    wire logic       sfr = REQ_ADDR_IN[15:8] == 8'hff;
    wire logic [7:0] off = REQ_ADDR_IN[7:0];
    wire logic       sys = CPU_MODE_IN == 3'h1;
    wire logic       fwm = CPU_MODE_IN == 3'h4;
    wire logic       fwa = REQ_ADDR_IN[15:12] == 4'he;
    wire logic       seg_on = SEG_EN_OUT[REQ_ADDR_IN[15:14]];
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);
    AST_MMU_SYS_ONLY: assert property (
        tk && sfr && off[7:4] == 4'h2 && !sys |=> VIOLATION_OUT && !BUS_VALID_OUT)
        else $error("MMU register reached outside system mode");
    AST_HW_SYS: assert property (
        tk && sfr && off[7:6] == 2'h1 && sys |=> BUS_VALID_OUT && BUS_ADDR_OUT == $past(REQ_ADDR_IN))
        else $error("System mode hardware register access not forwarded");
    AST_CPU_SFR_OPEN: assert property (
        tk && sfr && off < 8'h20 |=> BUS_VALID_OUT && !VIOLATION_OUT)
        else $error("CPU register access refused");
    AST_USER_BLOCK: assert property (
        tk && sfr && off >= 8'h20 && off[7:6] != 2'h1 && !sys |=> VIOLATION_OUT)
        else $error("Restricted register open outside system mode");
    AST_PTR_SYS: assert property (
        tk && REQ_WRITE_IN && sfr && off[7:2] == 6'h0a && !sys |=> !BUS_VALID_OUT)
        else $error("Segment table pointer written outside system mode");
    AST_SEG_RST: assert property (disable iff (1'b0)
        !RST_N_IN |=> SEG_EN_OUT == 4'h0 && !READY_OUT)
        else $error("Segments or ready not cleared by reset");
    AST_SEG_GATE: assert property (
        tk && !sfr && !fwa && !fwm |=> BUS_VALID_OUT == $past(seg_on))
        else $error("Memory access disagrees with segment enable");
    AST_BOOT: assert property (
        $rose(RST_N_IN) |-> !READY_OUT [*8] ##[1:4] READY_OUT)
        else $error("Boot sequence length wrong");
    AST_FW_PART: assert property (
        tk && !sfr && fwa && !fwm |=> VIOLATION_OUT && !BUS_VALID_OUT)
        else $error("Firmware partition reached from another mode");
    AST_DENY_READ: assert property (
        VIOLATION_OUT && RESP_VALID_OUT |-> RESP_RDATA_OUT == 8'h00 && !BUS_VALID_OUT)
        else $error("Denied read leaked data or reached the bus");
endmodule : mbrag_guard_props
bind mbrag_guard mbrag_guard_props u_props (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN),
    .REQ_VALID_IN(REQ_VALID_IN), .REQ_WRITE_IN(REQ_WRITE_IN), .REQ_ADDR_IN(REQ_ADDR_IN),
    .CPU_MODE_IN(CPU_MODE_IN), .READY_OUT(READY_OUT), .BUS_VALID_OUT(BUS_VALID_OUT),
    .BUS_ADDR_OUT(BUS_ADDR_OUT), .RESP_VALID_OUT(RESP_VALID_OUT),
    .RESP_RDATA_OUT(RESP_RDATA_OUT), .VIOLATION_OUT(VIOLATION_OUT), .SEG_EN_OUT(SEG_EN_OUT));
`default_nettype wire

/* File: tb/mbrag_mem_model.sv */
// Memory and register space behind the guard.
// Assumes read data is sampled by the guard at the edge after its bus pulse.
`timescale 1ns/1ps
`default_nettype none
module mbrag_mem_model (
    input  wire logic        clk_in,
    input  wire logic        bus_valid_in,
    input  wire logic        bus_write_in,
    input  wire logic [15:0] bus_addr_in,
    input  wire logic [7:0]  bus_wdata_in,
    output logic [7:0]       rdata_out
);
    logic [7:0] mem_reg [256];
    logic [7:0] idle_reg = 8'h00;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem_reg[i] = 8'(i) ^ 8'h3c;
    end
    // Idle data changes each cycle so stale reads cannot match
    always @(posedge clk_in)
    begin
        if (bus_valid_in && bus_write_in)
            mem_reg[bus_addr_in[7:0]] <= bus_wdata_in;
        idle_reg <= idle_reg + 8'h01;
    end
    assign rdata_out = (bus_valid_in && !bus_write_in) ? mem_reg[bus_addr_in[7:0]] : idle_reg;
endmodule : mbrag_mem_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the access guard with a memory model behind it.
// Assumes the checker binds itself to the guard.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [2:0] SY = mbrag_pkg::MODE_SYSTEM;
    localparam logic [2:0] US = mbrag_pkg::MODE_USER;
    localparam logic [2:0] FW = mbrag_pkg::MODE_FIRMWARE;
    localparam logic [9:0] DN = 10'h100;
    localparam logic [9:0] WOK = 10'h200;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_v = 1'b0;
    logic        req_w = 1'b0;
    logic [15:0] req_a = 16'h0000;
    logic [7:0]  req_d = 8'h00;
    logic [2:0]  mode = 3'h1;
    logic [7:0]  bus_rd;
    logic        rdy, bv, bw, rv, vio;
    logic [15:0] ba;
    logic [7:0]  bd, rd;
    logic [3:0]  seg;
    int          err_total = 0;
    int          total_checks = 0;
    initial forever #5 clk = ~clk;
    mbrag_guard DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(req_v),
        .REQ_WRITE_IN(req_w), .REQ_ADDR_IN(req_a), .REQ_WDATA_IN(req_d), .CPU_MODE_IN(mode),
        .BUS_RDATA_IN(bus_rd), .READY_OUT(rdy), .BUS_VALID_OUT(bv), .BUS_WRITE_OUT(bw),
        .BUS_ADDR_OUT(ba), .BUS_WDATA_OUT(bd), .RESP_VALID_OUT(rv), .RESP_RDATA_OUT(rd),
        .VIOLATION_OUT(vio), .SEG_EN_OUT(seg));
    mbrag_mem_model u_mem (.clk_in(clk), .bus_valid_in(bv), .bus_write_in(bw),
        .bus_addr_in(ba), .bus_wdata_in(bd), .rdata_out(bus_rd));
    task automatic test_done;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [9:0] rok(input logic [15:0] a);
        return {2'h2, a[7:0] ^ 8'h3c};
    endfunction : rok
    // One access; result packs bus pulse, violation and answered read data
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic [2:0] m, input logic [9:0] e);
        logic [9:0] r;
        @(posedge clk);
        {req_v, req_w, req_a, req_d, mode} <= {1'b1, w, a, d, m};
        @(posedge clk);
        req_v <= 1'b0;
        #1 r = {bv, vio, (rv === 1'b1) ? rd : 8'h00};
        @(posedge clk);
        #1 if (rv === 1'b1) r[7:0] = rd;
        chk(r, e);
    endtask : acc
    task automatic s_boot;
        int n;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({6'h00, seg}, 10'h000);
        n = 0;
        while (rdy !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk(10'(n), 10'h009);
    endtask : s_boot
    task automatic s_sfr;
        acc(1'b0, 16'hff05, 8'h00, US, rok(16'hff05));
        acc(1'b0, 16'hff90, 8'h00, US, DN);
        acc(1'b0, 16'hff21, 8'h00, US, DN);
        acc(1'b0, 16'hff22, 8'h00, FW, DN);
        acc(1'b0, 16'hff21, 8'h00, 3'h0, DN);
        acc(1'b1, 16'hff20, 8'h01, SY, WOK);
        chk({6'h00, seg}, 10'h001);
        acc(1'b1, 16'hff28, 8'h5a, SY, WOK);
        acc(1'b0, 16'hff28, 8'h00, SY, 10'h25a);
        acc(1'b1, 16'hff29, 8'h5a, US, DN);
        acc(1'b1, 16'hff2a, 8'h5a, FW, DN);
    endtask : s_sfr
    task automatic s_grant;
        acc(1'b0, 16'hff48, 8'h00, SY, rok(16'hff48));
        acc(1'b0, 16'hff48, 8'h00, US, DN);
        acc(1'b0, 16'hff50, 8'h00, FW, DN);
        acc(1'b1, 16'hff2c, 8'h02, US, DN);
        acc(1'b1, 16'hff2c, 8'h02, SY, WOK);
        acc(1'b0, 16'hff48, 8'h00, US, rok(16'hff48));
        acc(1'b0, 16'hff50, 8'h00, US, DN);
        acc(1'b0, 16'hff49, 8'h00, FW, rok(16'hff49));
    endtask : s_grant
    task automatic s_mem;
        acc(1'b0, 16'h8000, 8'h00, SY, DN);
        acc(1'b0, 16'h0010, 8'h00, US, rok(16'h0010));
        acc(1'b0, 16'he010, 8'h00, SY, DN);
        acc(1'b0, 16'he011, 8'h00, US, DN);
        acc(1'b1, 16'he012, 8'h55, SY, DN);
        acc(1'b0, 16'h0012, 8'h00, FW, rok(16'h0012));
        acc(1'b0, 16'he013, 8'h00, FW, rok(16'he013));
        acc(1'b0, 16'h8001, 8'h00, FW, rok(16'h8001));
    endtask : s_mem
    initial
    begin
        s_boot();
        s_sfr();
        s_grant();
        s_mem();
        s_boot();
        acc(1'b0, 16'hff48, 8'h00, US, DN);
        acc(1'b0, 16'h0010, 8'h00, SY, DN);
        test_done();
    end
    initial
    begin
        #50us;
        err_total++;
        test_done();
    end
endmodule : tb
`default_nettype wire
